/* File: logic/apd_defines.svh */
// Register map, field positions, reset values and timing counts of the amplifier supervisor
`ifndef APD_DEFINES_SVH
`define APD_DEFINES_SVH

`define APD_CLK_HZ 25000000
`define APD_RETRY_TIME_MS 50
`define APD_RETRY_CYCLES ((`APD_RETRY_TIME_MS * `APD_CLK_HZ) / 1000)
`define APD_RETRY_CNT_W 21
`define APD_LOAD_DET_CYCLES 2000
`define APD_MUTE_CYCLES 64
`define APD_TMR_W 16

`define APD_ADDR_CTRL 2'h0
`define APD_ADDR_STATUS 2'h1
`define APD_ADDR_LIVE 2'h2

`define APD_CTRL_RESET 8'h00
`define APD_CTRL_CH1_EN 0
`define APD_CTRL_CH2_EN 1
`define APD_CTRL_FAULT_INDICATOR_OUT_SUPPRESS 2
`define APD_CTRL_SHDN_INHIBIT 3
`define APD_CTRL_LOAD_DET_EN 4
`define APD_CTRL_CLIP_CH1 5
`define APD_CTRL_CLIP_CH2 6
`define APD_CTRL_PREWARN 7

`define APD_ST_CH1_OCP 0
`define APD_ST_CH2_OCP 1
`define APD_ST_OFFSET 2
`define APD_ST_CH1_LOAD 3
`define APD_ST_CH2_LOAD 4
`define APD_ST_LOAD_VALID 5
`define APD_ST_UV 6
`define APD_ST_OV 7
`define APD_ST_OTP 8
`define APD_ST_POR 9
`define APD_STATUS_RESET 10'h200
`define APD_STATUS_RC_MASK 10'h3c7

`endif

/* File: logic/apd_pkg.sv */
// Types shared by the amplifier protection and diagnostic supervisor
package apd_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WINDOW,
        ST_LOAD_DET,
        ST_MUTE,
        ST_RUN,
        ST_MUTE_DOWN
    } apd_state_t;

    // Analog comparator and strap levels as seen after synchronisation
    typedef struct packed {
        logic [1:0] load_open;
        logic [1:0] clip;
        logic prewarn;
        logic foldback;
        logic otp;
        logic ov;
        logic uv;
        logic offset;
        logic [1:0] window_short;
        logic [1:0] overcurrent_protect;
        logic bus_mode;
        logic protect_en;
        logic enable;
    } apd_sense_t;

    typedef struct packed {
        logic [1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } apd_bus_req_t;

endpackage

/* File: logic/apd_amp_protect.sv */
// Protection, restart policy and diagnostic indicator logic for a two-channel switching amplifier
`timescale 1ns/1ns
`include "apd_defines.svh"

module apd_amp_protect #(
    parameter int RETRY_CYCLES = `APD_RETRY_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Pins and comparators, asynchronous to clock_in
    input wire logic enable_in,
    input wire logic bus_mode_in,
    input wire logic offset_protect_in,
    input wire logic [1:0] overcurrent_protect_in,
    input wire logic [1:0] window_short_in,
    input wire logic offset_detect_in,
    input wire logic undervoltage_protect_in,
    input wire logic overvoltage_protect_in,
    input wire logic overtemp_in,
    input wire logic thermal_gain_foldback_in,
    input wire logic prewarn_in,
    input wire logic [1:0] clip_in,
    input wire logic [1:0] load_open_in,
    // Power stage control
    output logic [1:0] switch_en_out,
    output logic mute_out,
    output logic load_test_out,
    // Open-drain indicators
    output logic fault_indicator_out,
    output logic fault_indicator_oe_out,
    output logic clip_indicator_out,
    output logic clip_indicator_oe_out
);

    localparam logic [`APD_RETRY_CNT_W-1:0] RETRY_LOAD = `APD_RETRY_CNT_W'(RETRY_CYCLES - 1);
    localparam logic [`APD_TMR_W-1:0] LD_LOAD = `APD_TMR_W'(`APD_LOAD_DET_CYCLES - 1);
    localparam logic [`APD_TMR_W-1:0] MUTE_LOAD = `APD_TMR_W'(`APD_MUTE_CYCLES - 1);

    // Reset release
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Input synchroniser
    apd_pkg::apd_sense_t raw;
    apd_pkg::apd_sense_t sync1_q;
    apd_pkg::apd_sense_t s;
    assign raw = '{load_open: load_open_in, clip: clip_in, prewarn: prewarn_in,
                   foldback: thermal_gain_foldback_in, otp: overtemp_in,
                   ov: overvoltage_protect_in, uv: undervoltage_protect_in,
                   offset: offset_detect_in, window_short: window_short_in,
                   overcurrent_protect: overcurrent_protect_in, bus_mode: bus_mode_in,
                   protect_en: offset_protect_in, enable: enable_in};
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            s <= '0;
        end else begin
            sync1_q <= raw;
            s <= sync1_q;
        end
    end

    // Bus slave: one wait cycle, then the answer
    apd_pkg::apd_bus_req_t req;
    logic ack_q;
    logic [31:0] readdata_q;
    logic [7:0] ctrl_q;
    logic [9:0] status_q;
    logic [31:0] live_word;
    logic [31:0] rd_mux;
    wire bus_req = avs_read_in | avs_write_in;
    assign req = '{address: avs_address_in[3:2], read: avs_read_in,
                   write: avs_write_in, writedata: avs_writedata_in};
    assign avs_waitrequest_out = bus_req & ~ack_q;
    assign avs_readdata_out = readdata_q;
    wire wr_ctrl = ack_q & req.write & (req.address == `APD_ADDR_CTRL);
    wire rd_status = ack_q & req.read & (req.address == `APD_ADDR_STATUS);
    assign rd_mux = (req.address == `APD_ADDR_CTRL) ? {24'h000000, ctrl_q} :
                    (req.address == `APD_ADDR_STATUS) ? {22'h000000, status_q} :
                    (req.address == `APD_ADDR_LIVE) ? live_word : 32'h00000000;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q) begin
                readdata_q <= rd_mux;
            end
        end
    end

    // Control bits; cleared by reset so a fresh command is needed
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `APD_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= req.writedata[7:0];
        end
    end

    wire bus_mode = s.bus_mode;
    wire [1:0] ch_req = bus_mode ? {ctrl_q[`APD_CTRL_CH2_EN], ctrl_q[`APD_CTRL_CH1_EN]} : 2'h3;
    wire load_det_en = bus_mode & ctrl_q[`APD_CTRL_LOAD_DET_EN];
    wire fault_indicator_out_suppress = bus_mode & ctrl_q[`APD_CTRL_FAULT_INDICATOR_OUT_SUPPRESS];
    wire shdn_inhibit = bus_mode & ctrl_q[`APD_CTRL_SHDN_INHIBIT];
    wire prot_en = s.protect_en;

    // Synchronised levels are only trusted once the pin value has crossed both flops
    logic [1:0] sync_ok_q;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_ok_q <= 2'h0;
        end else begin
            sync_ok_q <= {sync_ok_q[0], 1'b1};
        end
    end

    // Power-on reset indication; in bus mode it stays until the host writes the control register
    logic por_q;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            por_q <= 1'b1;
        end else if (wr_ctrl | (sync_ok_q[1] & ~bus_mode)) begin
            por_q <= 1'b0;
        end
    end

    // Sequencer
    apd_pkg::apd_state_t state_q;
    apd_pkg::apd_state_t state_d;
    logic [`APD_TMR_W-1:0] tmr_q;
    logic offset_latch_q;
    logic en_prev_q;
    logic ld_done_q;
    logic [1:0] ch_on_q;
    logic [1:0] sw_q;
    logic mute_q;

    wire sw_active = (state_q == apd_pkg::ST_MUTE) | (state_q == apd_pkg::ST_RUN) |
                     (state_q == apd_pkg::ST_MUTE_DOWN);
    wire hard_fault = s.ov | s.otp | offset_latch_q;
    wire amp_req = s.enable & (|ch_req) & ~por_q & ~s.uv & ~hard_fault;
    wire tmr_zero = (tmr_q == '0);
    wire offset_hit = s.offset & prot_en & sw_active;
    wire offset_shdn = offset_hit & ~shdn_inhibit;
    wire en_toggle = s.enable ^ en_prev_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            apd_pkg::ST_OFF: begin
                if (amp_req) begin
                    state_d = apd_pkg::ST_WINDOW;
                end
            end
            apd_pkg::ST_WINDOW: begin
                if (!amp_req) begin
                    state_d = apd_pkg::ST_OFF;
                end else if (|s.window_short) begin
                    state_d = apd_pkg::ST_WINDOW;
                end else if (load_det_en & ~ld_done_q) begin
                    state_d = apd_pkg::ST_LOAD_DET;
                end else begin
                    state_d = apd_pkg::ST_MUTE;
                end
            end
            apd_pkg::ST_LOAD_DET: begin
                if (!amp_req) begin
                    state_d = apd_pkg::ST_OFF;
                end else if (tmr_zero) begin
                    state_d = apd_pkg::ST_MUTE;
                end
            end
            apd_pkg::ST_MUTE: begin
                if (hard_fault | offset_shdn) begin
                    state_d = apd_pkg::ST_OFF;
                end else if (!amp_req) begin
                    state_d = apd_pkg::ST_MUTE_DOWN;
                end else if (tmr_zero) begin
                    state_d = apd_pkg::ST_RUN;
                end
            end
            apd_pkg::ST_RUN: begin
                if (hard_fault | offset_shdn) begin
                    state_d = apd_pkg::ST_OFF;
                end else if (!amp_req) begin
                    state_d = apd_pkg::ST_MUTE_DOWN;
                end
            end
            apd_pkg::ST_MUTE_DOWN: begin
                if (hard_fault | offset_shdn | tmr_zero) begin
                    state_d = apd_pkg::ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= apd_pkg::ST_OFF;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                tmr_q <= (state_d == apd_pkg::ST_LOAD_DET) ? LD_LOAD : MUTE_LOAD;
            end else if (!tmr_zero) begin
                tmr_q <= tmr_q - `APD_TMR_W'(1);
            end
        end
    end

    // Offset shutdown latch; no self restart
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            offset_latch_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= s.enable;
            if (offset_shdn) begin
                offset_latch_q <= 1'b1;
            end else if (en_toggle | ~prot_en) begin
                offset_latch_q <= 1'b0;
            end
        end
    end

    // Load detection runs once per enable bit setting
    logic [1:0] load_res_q;
    logic load_valid_q;
    wire ld_finish = (state_q == apd_pkg::ST_LOAD_DET) & tmr_zero & amp_req;
    wire ld_abort = (state_q == apd_pkg::ST_LOAD_DET) & (s.uv | s.ov);
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ld_done_q <= 1'b0;
            load_res_q <= 2'h0;
            load_valid_q <= 1'b0;
        end else begin
            if (!load_det_en) begin
                ld_done_q <= 1'b0;
            end else if (ld_finish) begin
                ld_done_q <= 1'b1;
            end
            if (ld_finish) begin
                load_res_q <= s.load_open;
                load_valid_q <= 1'b1;
            end else if (ld_abort) begin
                load_valid_q <= 1'b0;
            end
        end
    end

    // Per-channel overcurrent shutdown and timed retry
    logic [`APD_RETRY_CNT_W-1:0] retry_q [2];
    for (genvar i = 0; i < 2; i++) begin : g_ch
        always_ff @(posedge clock_in or negedge rst_n) begin
            if (!rst_n) begin
                ch_on_q[i] <= 1'b1;
                retry_q[i] <= '0;
            end else if (ch_on_q[i]) begin
                if (s.overcurrent_protect[i] & sw_q[i]) begin
                    ch_on_q[i] <= 1'b0;
                    retry_q[i] <= RETRY_LOAD;
                end
            end else if (retry_q[i] != '0) begin
                retry_q[i] <= retry_q[i] - `APD_RETRY_CNT_W'(1);
            end else if (!s.window_short[i]) begin
                ch_on_q[i] <= 1'b1;
            end
        end
    end

    // Switching, mute and indicators from flip-flops
    wire [1:0] sw_d = {2{sw_active}} & ch_on_q & ch_req;
    wire mute_d = (state_q != apd_pkg::ST_RUN);
    wire offset_fault_indicator_out = s.offset & prot_en & (sw_active | offset_latch_q) & ~fault_indicator_out_suppress;
    wire fault_indicator_out_d = por_q | s.uv | s.ov | (|s.overcurrent_protect) | (|s.window_short) | s.otp |
                  offset_fault_indicator_out;
    wire [1:0] clip_sel = {ctrl_q[`APD_CTRL_CLIP_CH2], ctrl_q[`APD_CTRL_CLIP_CH1]};
    wire clip_d = bus_mode ? ((|(s.clip & clip_sel)) | (s.prewarn & ctrl_q[`APD_CTRL_PREWARN]))
                           : ((|s.clip) | s.prewarn);
    logic fault_indicator_out_q;
    logic clip_q;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sw_q <= 2'h0;
            mute_q <= 1'b1;
            fault_indicator_out_q <= 1'b0;
            clip_q <= 1'b0;
        end else begin
            sw_q <= sw_d;
            mute_q <= mute_d;
            fault_indicator_out_q <= fault_indicator_out_d;
            clip_q <= clip_d;
        end
    end
    assign switch_en_out = sw_q;
    assign mute_out = mute_q;
    assign load_test_out = (state_q == apd_pkg::ST_LOAD_DET);
    // Open-drain: the data line is a constant low, only the enable moves
    assign fault_indicator_out = 1'b0;
    assign fault_indicator_oe_out = fault_indicator_out_q;
    assign clip_indicator_out = 1'b0;
    assign clip_indicator_oe_out = clip_q;

    // Status: hardware set wins over the read clear
    wire [9:0] st_set = {por_q, s.otp, s.ov, s.uv, 3'h0, offset_hit & bus_mode,
                         s.overcurrent_protect | s.window_short};
    wire [9:0] st_clr = rd_status ? `APD_STATUS_RC_MASK : 10'h000;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `APD_STATUS_RESET;
        end else begin
            status_q[`APD_ST_CH2_LOAD:`APD_ST_CH1_LOAD] <= load_res_q;
            status_q[`APD_ST_LOAD_VALID] <= load_valid_q;
            status_q[9:6] <= (status_q[9:6] & ~st_clr[9:6]) | st_set[9:6];
            status_q[2:0] <= (status_q[2:0] & ~st_clr[2:0]) | st_set[2:0];
        end
    end

    assign live_word = {14'h0000, s.foldback, s.prewarn, s.clip, s.otp, s.ov, s.uv,
                        offset_latch_q, ch_on_q, sw_q, mute_q, 1'b0, 3'(state_q), por_q};

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    sequence seq_ocp_trip(int ch);
        ch_on_q[ch] && sw_q[ch] && s.overcurrent_protect[ch];
    endsequence

    a_window_holds_start: assert property (
        state_q == apd_pkg::ST_WINDOW && (|s.window_short) |=> state_q != apd_pkg::ST_MUTE
    ) else $error("start-up passed the window check with a short present");

    a_ocp_drops_channel: assert property (
        seq_ocp_trip(0) |=> !ch_on_q[0] ##1 !sw_q[0]
    ) else $error("channel 1 kept switching after an overcurrent trip");

    a_retry_waits_short: assert property (
        !ch_on_q[1] && s.window_short[1] |=> !ch_on_q[1]
    ) else $error("channel 2 restarted while its output was still shorted");

    a_offset_latch_holds: assert property (
        offset_latch_q && !en_toggle && prot_en |=> offset_latch_q
    ) else $error("offset shutdown released without enable toggle or disable");

    a_offset_stops_all: assert property (
        offset_shdn |=> state_q == apd_pkg::ST_OFF ##1 sw_q == 2'h0
    ) else $error("offset shutdown did not stop both channels");

    a_no_prot_no_latch: assert property (
        !prot_en |=> !offset_latch_q
    ) else $error("offset latch set while protection disabled");

    a_uv_mutes_first: assert property (
        state_q == apd_pkg::ST_RUN && s.uv && !hard_fault |=> ##1 mute_q && (sw_q == $past(sw_q))
    ) else $error("undervoltage stopped switching before muting");

    a_ov_full_stop: assert property (
        s.ov && sw_active |=> ##1 sw_q == 2'h0
    ) else $error("overvoltage did not stop all power stages");

    a_status_read_clear: assert property (
        rd_status && st_set[0] == 1'b0 |=> status_q[`APD_ST_CH1_OCP] == 1'b0
    ) else $error("status read did not clear the channel 1 short bit");

    a_fault_indicator_out_follows_live: assert property (
        (|s.overcurrent_protect) |=> fault_indicator_oe_out
    ) else $error("fault indicator not pulled for a live short");

    a_ld_bus_only: assert property (
        state_q == apd_pkg::ST_LOAD_DET |-> bus_mode && ctrl_q[`APD_CTRL_LOAD_DET_EN]
    ) else $error("load detection ran without bus mode and enable bit");

endmodule // apd_amp_protect

/* File: verif/apd_amp_model.sv */
// Behavioural power stage and loudspeaker load seen by the supervisor
`timescale 1ns/1ns
module apd_amp_model (
    input wire logic [1:0] switch_en_in,
    input wire logic load_test_in,
    input wire logic [1:0] load_short_in,
    input wire logic [1:0] supply_short_in,
    input wire logic [1:0] open_in,
    output logic [1:0] ocp_out,
    output logic [1:0] window_out,
    output logic [1:0] load_open_out
);
    // A short only draws current while its stage is switching
    assign ocp_out = switch_en_in & (load_short_in | supply_short_in);
    // The window comparator sees a supply short even with the stage off
    assign window_out = supply_short_in;
    // Open-load comparator is meaningless outside the test pulse, so it reads zero
    assign load_open_out = load_test_in ? open_in : 2'h0;
endmodule // apd_amp_model

/* File: verif/amp_protection_fault_indicator_out_test.sv */
// Self-checking bench for the amplifier protection supervisor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module amp_protection_fault_indicator_out_test;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic waitreq, mute, ltest, fi, fi_oe, ci, ci_oe;
    logic en = 1'b1;
    logic bus = 1'b1;
    logic prot = 1'b1;
    logic ofs = 1'b0;
    logic [3:0] flt = 4'h0;
    logic pw = 1'b0;
    logic [1:0] clip = 2'h0;
    logic [1:0] lsh = 2'h0;
    logic [1:0] ssh = 2'h0;
    logic [1:0] opn = 2'h0;
    logic [1:0] overcurrent_protect, win, lopen, sw;
    int n_errors = 0;
    int n_compared = 0;
    int waited;
    int k;
    always #20 clock_in = ~clock_in;
    apd_amp_protect #(.RETRY_CYCLES(20)) u_apd_amp_protect (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .enable_in(en), .bus_mode_in(bus), .offset_protect_in(prot),
        .overcurrent_protect_in(overcurrent_protect), .window_short_in(win), .offset_detect_in(ofs),
        .undervoltage_protect_in(flt[0]), .overvoltage_protect_in(flt[1]),
        .overtemp_in(flt[2]), .thermal_gain_foldback_in(flt[3]), .prewarn_in(pw),
        .clip_in(clip), .load_open_in(lopen), .switch_en_out(sw), .mute_out(mute),
        .load_test_out(ltest), .fault_indicator_out(fi), .fault_indicator_oe_out(fi_oe),
        .clip_indicator_out(ci), .clip_indicator_oe_out(ci_oe));
    apd_amp_model u_apd_amp_model (
        .switch_en_in(sw), .load_test_in(ltest), .load_short_in(lsh),
        .supply_short_in(ssh), .open_in(opn), .ocp_out(overcurrent_protect), .window_out(win),
        .load_open_out(lopen));
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Request is held until the edge that follows a low waitrequest
    task automatic bus_op(input logic w, input logic [3:0] a, input logic [31:0] v);
        int i;
        @(posedge clock_in);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= v;
        @(negedge clock_in);
        for (i = 0; i < 50 && waitreq !== 1'b0; i++) @(negedge clock_in);
        if (waitreq !== 1'b0) begin
            n_errors++;
            test_done();
        end
        @(posedge clock_in);
        d = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Waits on {load_test, mute, switch} under a mask, counting cycles
    task automatic wait_for(input logic [3:0] e, input logic [3:0] m);
        for (waited = 0; waited < 4000 && ({ltest, mute, sw} & m) !== e; waited++)
            @(negedge clock_in);
        if (({ltest, mute, sw} & m) !== e) begin
            n_errors++;
            test_done();
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic toggle_en();
        @(posedge clock_in) en <= 1'b0;
        wait_for(4'h4, 4'h7);
        settle(5);
        @(posedge clock_in) en <= 1'b1;
    endtask
    initial begin
        repeat (100000) @(posedge clock_in);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        reset_n_in <= 1'b1;
        settle(8);
        `CHK("fault pin level", 1'b0, fi)
        `CHK("power-on on fault pin", 1'b1, fi_oe)
        `CHK("idle before command", 2'h0, sw)
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("status after reset", 10'h200, d[9:0] & 10'h3c7)
        bus_op(1'b1, 4'h0, 32'h3);
        wait_for(4'h3, 4'hf);
        `CHK("power-on released", 1'b0, fi_oe)
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("first status read", 10'h200, d[9:0] & 10'h3c7)
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("second status read", 10'h0, d[9:0] & 10'h3c7)
        bus_op(1'b0, 4'hc, 32'h0);
        `CHK("unmapped read", 32'h0, d)
        $display("start-up test done");
        @(posedge clock_in) lsh <= 2'h1;
        wait_for(4'h2, 4'h3);
        settle(1);
        `CHK("fault pin on short", 1'b1, fi_oe)
        wait_for(4'h3, 4'h3);
        `CHK("retry interval", 1'b1, waited > 14 && waited < 40)
        wait_for(4'h2, 4'h3);
        @(posedge clock_in) lsh <= 2'h0;
        wait_for(4'h3, 4'h3);
        settle(4);
        `CHK("fault pin live", 1'b0, fi_oe)
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("short latched", 1'b1, d[0])
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("short cleared by read", 1'b0, d[0])
        @(posedge clock_in) ssh <= 2'h2;
        wait_for(4'h1, 4'h3);
        settle(80);
        `CHK("held by window", 2'h1, sw)
        `CHK("window on fault pin", 1'b1, fi_oe)
        @(posedge clock_in) ssh <= 2'h0;
        wait_for(4'h3, 4'h3);
        $display("short test done");
        toggle_en();
        wait_for(4'h7, 4'h7);
        @(posedge clock_in) ofs <= 1'b1;
        wait_for(4'h4, 4'h7);
        settle(4);
        `CHK("offset on fault pin", 1'b1, fi_oe)
        @(posedge clock_in) ofs <= 1'b0;
        settle(200);
        `CHK("offset latched", 3'h4, {mute, sw})
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("offset alarm", 1'b1, d[2])
        toggle_en();
        wait_for(4'h3, 4'h7);
        @(posedge clock_in) ofs <= 1'b1;
        wait_for(4'h4, 4'h7);
        @(posedge clock_in) prot <= 1'b0;
        wait_for(4'h3, 4'h7);
        settle(50);
        `CHK("protection off", 3'h3, {mute, sw})
        @(posedge clock_in) ofs <= 1'b0;
        settle(5);
        @(posedge clock_in) prot <= 1'b1;
        bus_op(1'b1, 4'h0, 32'hf);
        @(posedge clock_in) ofs <= 1'b1;
        settle(50);
        `CHK("shutdown inhibited", 3'h3, {mute, sw})
        `CHK("offset pin suppressed", 1'b0, fi_oe)
        @(posedge clock_in) ofs <= 1'b0;
        $display("offset test done");
        for (k = 0; k < 4; k++) begin
            @(posedge clock_in) flt <= 4'h1 << k;
            if (k == 0)
                wait_for(4'h7, 4'h7);
            if (k < 3)
                wait_for(4'h4, 4'h7);
            settle(50);
            `CHK("fault pin per fault", k < 3, fi_oe)
            `CHK("stage per fault", k < 3 ? 3'h4 : 3'h3, {mute, sw})
            @(posedge clock_in) flt <= 4'h0;
            wait_for(4'h3, 4'h7);
        end
        $display("supply and thermal test done");
        bus_op(1'b1, 4'h0, 32'h23);
        @(posedge clock_in) clip <= 2'h1;
        settle(5);
        `CHK("clip selected", 1'b1, ci_oe)
        `CHK("clip pin level", 1'b0, ci)
        @(posedge clock_in) clip <= 2'h2;
        pw <= 1'b1;
        settle(5);
        `CHK("clip not selected", 1'b0, ci_oe)
        bus_op(1'b1, 4'h0, 32'ha3);
        settle(5);
        `CHK("prewarn selected", 1'b1, ci_oe)
        @(posedge clock_in) pw <= 1'b0;
        clip <= 2'h0;
        bus_op(1'b1, 4'h0, 32'h0);
        wait_for(4'h4, 4'h7);
        @(posedge clock_in) opn <= 2'h2;
        bus_op(1'b1, 4'h0, 32'h13);
        wait_for(4'hc, 4'hf);
        wait_for(4'h3, 4'hf);
        `CHK("start-up lengthened", 1'b1, waited >= 2000)
        bus_op(1'b0, 4'h4, 32'h0);
        `CHK("load result", 3'h6, d[5:3])
        $display("load test done");
        bus_op(1'b1, 4'h0, 32'hf);
        bus <= 1'b0;
        ofs <= 1'b1;
        settle(300);
        `CHK("standalone offset pin", 1'b1, fi_oe)
        `CHK("standalone shutdown", 2'h0, sw)
        $display("standalone test done");
        test_done();
    end
endmodule // amp_protection_fault_indicator_out_test
